// *** hdl/ssp_pkg.sv ***
package ssp_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_BUF    = 4'h0;  // serial_buffer
    localparam logic [3:0] ADDR_STAT   = 4'h4;  // serial_port_status
    localparam logic [3:0] ADDR_CTRL   = 4'h8;  // serial_port_control
    localparam logic [3:0] ADDR_SLVA   = 4'hC;  // own slave address
    localparam logic [3:0] ADDR_DIR    = 4'h0;  // port_c_direction (word 0x10)
    localparam logic [3:0] ADDR_IRQ    = 4'h4;  // irq flag / enable (word 0x14)
    localparam int         ADDR_HI_BIT = 4;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int STAT_RW    = 2;
    localparam int STAT_START = 3;
    localparam int STAT_STOP  = 4;
    localparam int STAT_DA    = 5;
    localparam int STAT_FULL  = 0;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_MODE_HI = 3;
    localparam int CTRL_RELEASE = 4;
    localparam int CTRL_ENABLE  = 5;
    localparam logic [3:0] MODE_SLAVE7  = 4'h6;
    localparam logic [3:0] MODE_SLVIDLE = 4'hB;
    localparam int DIR_SDA = 4;
    localparam int DIR_SCL = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DIR_RST  = 8'hFF;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Slave byte engine states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_HOLD = 5'b00100,
        ST_SEND = 5'b01000,
        ST_ACK  = 5'b10000
    } ssp_state_type;
endpackage : ssp_pkg

// *** hdl/ssp_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; output changes when stages two and three agree
module ssp_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Asynchronous level in, filtered level out
    input  wire logic d_i,
    output logic      q_o
);
    logic [2:0] s_r;

    // Shift chain, idle high like the bus lines
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= 3'h7;
            q_o <= 1'b1;
        end else begin
            s_r <= {s_r[1:0], d_i};
            if (s_r[1] == s_r[2]) begin
                q_o <= s_r[2];
            end
        end
    end
endmodule : ssp_sync

// *** hdl/ssp_cond.sv ***
`timescale 1ns/1ps
// Edge and START/STOP detection on the synchronised bus lines
module ssp_cond (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Synchronised lines
    input  wire logic scl_i,
    input  wire logic sda_i,
    // One-cycle events
    output logic      scl_rise_o,
    output logic      scl_fall_o,
    output logic      start_o,
    output logic      stop_o
);
    logic scl_d_r;
    logic sda_d_r;

    // Previous levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_i;
            sda_d_r <= sda_i;
        end
    end

    assign scl_rise_o = scl_i & ~scl_d_r;
    assign scl_fall_o = ~scl_i & scl_d_r;
    assign start_o    = scl_i & scl_d_r & sda_d_r & ~sda_i;
    assign stop_o     = scl_i & scl_d_r & ~sda_d_r & sda_i;
endmodule : ssp_cond

// *** hdl/ssp_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Matched read address sets the read/write status bit.
// - Matched read address byte is placed in the serial buffer.
// - After matched read, acknowledge ninth bit then hold clock low.
// - Software write of serial buffer also loads the shift register.
// - Clock stays stretched until software sets release bit 4 of control.
// - Eight data bits leave MSB first, changing on falling clock edges.
// - Interrupt flag per byte, held until software clears it.
// - Interrupt flag set on falling edge of ninth clock pulse.
// - Master acknowledge sampled on rising edge of ninth clock.
// - Not-acknowledge ends transfer, resets status, waits for START.
// - On acknowledge software reloads byte and releases clock; shifting resumes.
// - START and STOP bits clear on reset or module disable.
// - START and STOP bits follow conditions seen on the bus.
// - Clearing direction bits 4:3 drives the pins low; setting releases.
// - Interrupt flag set on START, STOP and each byte.
// - Master works with mode 1011 or slave active.
module ssp_top (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // I2C pins, open drain
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // Serial port interrupt flag, gated by its enable
    output logic             irq_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]  buf_r, shift_r, ctrl_r, slva_r, dir_r, stat_r;
    logic        flag_r, irq_en_r, full_r;
    logic [3:0]  bit_r;
    logic        ack_drv_r, data_low_r;
    ssp_pkg::ssp_state_type state_r;
    logic        scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
    logic        wr, rd, enable, slave_on, hi;
    logic [3:0]  lo;
    localparam logic [3:0] BIT_LAST_M1 = 4'h7;  // Count of the last data bit before the acknowledge slot
    assign enable   = ctrl_r[ssp_pkg::CTRL_ENABLE];
    assign slave_on = enable &&
                      ctrl_r[ssp_pkg::CTRL_MODE_HI:ssp_pkg::CTRL_MODE_LO] == ssp_pkg::MODE_SLAVE7;
    assign wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
    assign rd = cyc_i & stb_i & ~we_i & ~ack_o;
    assign hi = adr_i[ssp_pkg::ADDR_HI_BIT];
    assign lo = adr_i[3:0];
    // ------------------------------------------------------------
    // Pin synchronisers and condition detection
    // ------------------------------------------------------------
    ssp_sync u_sync_scl (.clk_i(clk_i), .rst_i(rst_i), .d_i(scl_i), .q_o(scl_s));
    ssp_sync u_sync_sda (.clk_i(clk_i), .rst_i(rst_i), .d_i(sda_i), .q_o(sda_s));
    ssp_cond u_cond (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .scl_i      (scl_s),
        .sda_i      (sda_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start_ev),
        .stop_o     (stop_ev)
    );
    // ------------------------------------------------------------
    // Wishbone answer: one wait-free cycle, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            dat_o <= 32'h0;
            if (rd && !hi) begin
                case (lo)
                    ssp_pkg::ADDR_BUF:  dat_o[7:0] <= buf_r;
                    ssp_pkg::ADDR_STAT: dat_o[7:0] <= stat_r;
                    ssp_pkg::ADDR_CTRL: dat_o[7:0] <= ctrl_r;
                    ssp_pkg::ADDR_SLVA: dat_o[7:0] <= slva_r;
                    default:            dat_o      <= 32'h0;
                endcase
            end else if (rd && hi) begin
                case (lo)
                    ssp_pkg::ADDR_DIR: dat_o[7:0] <= dir_r;
                    ssp_pkg::ADDR_IRQ: dat_o[1:0] <= {irq_en_r, flag_r};
                    default:           dat_o      <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Control, address and direction registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= ssp_pkg::CTRL_RST;
            slva_r   <= 8'h00;
            dir_r    <= ssp_pkg::DIR_RST;
            irq_en_r <= 1'b0;
        end else begin
            if (wr && !hi && lo == ssp_pkg::ADDR_CTRL) begin
                ctrl_r <= dat_i[7:0];
            end else if (state_r == ssp_pkg::ST_ACK && scl_fall) begin
                ctrl_r[ssp_pkg::CTRL_RELEASE] <= 1'b0;
            end
            if (wr && !hi && lo == ssp_pkg::ADDR_SLVA) begin
                slva_r <= dat_i[7:0];
            end
            if (wr && hi && lo == ssp_pkg::ADDR_DIR) begin
                dir_r <= dat_i[7:0];
            end
            if (wr && hi && lo == ssp_pkg::ADDR_IRQ) begin
                irq_en_r <= dat_i[1];
            end
        end
    end
    // ------------------------------------------------------------
    // Interrupt flag: set wins over software clear (write 1 to clear)
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
            irq_o  <= 1'b0;
        end else begin
            if (enable && (start_ev || stop_ev || (state_r == ssp_pkg::ST_ACK && scl_fall)
                           || (state_r == ssp_pkg::ST_ADDR && scl_fall && bit_r == ssp_pkg::BIT_LAST
                               && ack_drv_r))) begin
                flag_r <= 1'b1;
            end else if (wr && hi && lo == ssp_pkg::ADDR_IRQ && dat_i[0]) begin
                flag_r <= 1'b0;
            end
            irq_o <= flag_r & irq_en_r;
        end
    end
    // ------------------------------------------------------------
    // Status register: START/STOP tracking and read/write bit
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable) begin
            stat_r <= 8'h00;
        end else begin
            if (start_ev) begin
                stat_r[ssp_pkg::STAT_START] <= 1'b1;
                stat_r[ssp_pkg::STAT_STOP]  <= 1'b0;
            end else if (stop_ev) begin
                stat_r[ssp_pkg::STAT_STOP]  <= 1'b1;
                stat_r[ssp_pkg::STAT_START] <= 1'b0;
                stat_r[ssp_pkg::STAT_RW]    <= 1'b0;
            end
            if (state_r == ssp_pkg::ST_ADDR && scl_fall && bit_r == ssp_pkg::BIT_LAST && ack_drv_r) begin
                stat_r[ssp_pkg::STAT_RW] <= 1'b1;
                stat_r[ssp_pkg::STAT_DA] <= 1'b0;
            end else if (state_r == ssp_pkg::ST_ACK && scl_fall && !data_low_r) begin
                stat_r[ssp_pkg::STAT_RW] <= 1'b0;
                stat_r[ssp_pkg::STAT_DA] <= 1'b0;
            end
            stat_r[ssp_pkg::STAT_FULL] <= full_r;
        end
    end
    // ------------------------------------------------------------
    // Slave transmitter engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !slave_on) begin
            state_r    <= ssp_pkg::ST_IDLE;
            bit_r      <= ssp_pkg::BIT_ZERO;
            shift_r    <= 8'h00;
            buf_r      <= 8'h00;
            full_r     <= 1'b0;
            ack_drv_r  <= 1'b0;
            data_low_r <= 1'b0;
        end else begin
            if (wr && !hi && lo == ssp_pkg::ADDR_BUF) begin
                buf_r   <= dat_i[7:0];
                shift_r <= dat_i[7:0];
                full_r  <= 1'b1;
            end
            if (rd && !hi && lo == ssp_pkg::ADDR_BUF) begin
                full_r <= 1'b0;
            end
            if (start_ev) begin
                state_r   <= ssp_pkg::ST_ADDR;
                bit_r     <= ssp_pkg::BIT_ZERO;
                ack_drv_r <= 1'b0;
            end else if (stop_ev) begin
                state_r   <= ssp_pkg::ST_IDLE;
                ack_drv_r <= 1'b0;
            end else begin
                case (state_r)
                    ssp_pkg::ST_ADDR: begin
                        if (scl_rise && bit_r != ssp_pkg::BIT_LAST) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_r   <= bit_r + 4'h1;
                        end
                        if (scl_fall && bit_r == ssp_pkg::BIT_LAST) begin
                            if (ack_drv_r) begin
                                ack_drv_r <= 1'b0;
                                state_r   <= ssp_pkg::ST_HOLD;
                            end else if (shift_r[7:1] == slva_r[7:1] && shift_r[0]) begin
                                buf_r     <= shift_r;
                                full_r    <= 1'b1;
                                ack_drv_r <= 1'b1;
                            end else begin
                                state_r <= ssp_pkg::ST_IDLE;
                            end
                        end
                    end
                    ssp_pkg::ST_HOLD: begin
                        // release once software sets the bit
                        bit_r <= ssp_pkg::BIT_ZERO;
                        if (ctrl_r[ssp_pkg::CTRL_RELEASE]) begin
                            state_r <= ssp_pkg::ST_SEND;
                        end
                    end
                    ssp_pkg::ST_SEND: begin
                        // next bit on each falling edge
                        if (scl_fall) begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            bit_r   <= bit_r + 4'h1;
                            if (bit_r == BIT_LAST_M1) begin
                                state_r <= ssp_pkg::ST_ACK;
                            end
                        end
                    end
                    ssp_pkg::ST_ACK: begin
                        if (scl_rise) begin
                            data_low_r <= ~sda_s;
                        end
                        if (scl_fall) begin
                            state_r <= data_low_r ? ssp_pkg::ST_HOLD : ssp_pkg::ST_IDLE;
                        end
                    end
                    default: state_r <= ssp_pkg::ST_IDLE;
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // Pin drivers: open drain, enable high means pulling low
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_o    <= 1'b0;
            sda_o    <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            // slave stretch and master drive combine
            scl_oe_o <= ~dir_r[ssp_pkg::DIR_SCL] | (state_r == ssp_pkg::ST_HOLD && !ctrl_r[ssp_pkg::CTRL_RELEASE]);
            sda_oe_o <= ~dir_r[ssp_pkg::DIR_SDA] | ack_drv_r
                        | ((state_r == ssp_pkg::ST_SEND || state_r == ssp_pkg::ST_HOLD) && !shift_r[7]);
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_stretch;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == ssp_pkg::ST_HOLD && !ctrl_r[ssp_pkg::CTRL_RELEASE]) |=> scl_oe_o;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not stretched");
    property p_load;
        @(posedge clk_i) disable iff (rst_i)
        (slave_on && wr && !hi && lo == ssp_pkg::ADDR_BUF) |=> (shift_r == buf_r);
    endproperty
    a_load: assert property (p_load) else $error("shift not loaded");
    property p_disable;
        @(posedge clk_i) disable iff (rst_i)
        !enable |=> (stat_r[ssp_pkg::STAT_START] == 1'b0 && stat_r[ssp_pkg::STAT_STOP] == 1'b0);
    endproperty
    a_disable: assert property (p_disable) else $error("start/stop not cleared");
    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        (enable && start_ev) |=> stat_r[ssp_pkg::STAT_START] && flag_r;
    endproperty
    a_start: assert property (p_start) else $error("start not flagged");
    property p_stop;
        @(posedge clk_i) disable iff (rst_i)
        (enable && stop_ev && !start_ev) |=> stat_r[ssp_pkg::STAT_STOP] && flag_r;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not flagged");
    property p_dir;
        @(posedge clk_i) disable iff (rst_i)
        !dir_r[ssp_pkg::DIR_SDA] |=> sda_oe_o && !sda_o;
    endproperty
    a_dir: assert property (p_dir) else $error("data pin not driven low");
    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        (slave_on && state_r == ssp_pkg::ST_ACK && scl_fall) |=> flag_r;
    endproperty
    a_irq: assert property (p_irq) else $error("byte flag missing");
    property p_nack;
        @(posedge clk_i) disable iff (rst_i)
        (slave_on && state_r == ssp_pkg::ST_ACK && scl_fall && !data_low_r && !start_ev && !stop_ev)
        |=> state_r == ssp_pkg::ST_IDLE;
    endproperty
    a_nack: assert property (p_nack) else $error("nack did not end transfer");
    property p_flag_hold;
        @(posedge clk_i) disable iff (rst_i)
        (flag_r && !(wr && hi && lo == ssp_pkg::ADDR_IRQ)) |=> flag_r;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
endmodule : ssp_top

// *** test/ssp_bus_master.sv ***
`timescale 1ns/1ps
// Behavioural I2C master on the far side, open drain on both lines
module ssp_bus_master (
    // Core clock paces the 160 ns link period
    input  wire logic clk_i,
    // Wired bus levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Pull-low enables
    output logic      scl_oe_o,
    output logic      sda_oe_o,
    // Set when the bus misbehaved
    output logic      stuck_o
);
    // Lines released at start
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        stuck_o  = 1'b0;
    end
    // Half a link period
    task automatic half;
        repeat (10) @(posedge clk_i);
    endtask : half
    task automatic clk_hi;
        int n;
        n = 0;
        scl_oe_o <= 1'b0;
        while (scl_i !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) stuck_o <= 1'b1;
        half();
    endtask : clk_hi
    task automatic bit_out(input logic b);
        sda_oe_o <= ~b;
        half();
        clk_hi();
        scl_oe_o <= 1'b1;
    endtask : bit_out
    // Sample the line at the end of the high phase
    task automatic bit_in(output logic b);
        sda_oe_o <= 1'b0;
        half();
        clk_hi();
        b = sda_i;
        scl_oe_o <= 1'b1;
    endtask : bit_in
    // Address or data byte towards the slave, then its acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(ack);
    endtask : wr_byte
    // Byte from the slave, then our acknowledge or not
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(nack);
    endtask : rd_byte
    task automatic start;
        if (scl_i !== 1'b1 || sda_i !== 1'b1) stuck_o <= 1'b1;
        sda_oe_o <= 1'b1;
        half();
        scl_oe_o <= 1'b1;
        half();
    endtask : start
    // Data rises while the clock is high
    task automatic stop;
        sda_oe_o <= 1'b1;
        half();
        clk_hi();
        sda_oe_o <= 1'b0;
        half();
    endtask : stop
endmodule : ssp_bus_master

// *** test/test_ssp_top.sv ***
`timescale 1ns/1ps
// Register-level bench with an I2C master on the pins
module test_ssp_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [4:0]  adr_i = 5'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic        ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o;
    logic        m_scl_oe, m_sda_oe, m_stuck, ackb;
    logic [7:0]  rx;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    // Wired bus with pull-ups
    wire logic   scl_w = ~(scl_oe_o | m_scl_oe);
    wire logic   sda_w = ~(sda_oe_o | m_sda_oe);
    // 125 MHz clock
    always #4 clk_i = ~clk_i;
    ssp_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
    ssp_bus_master m (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl_oe),
        .sda_oe_o(m_sda_oe), .stuck_o(m_stuck));
    // Verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Classic Wishbone single cycle
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            $display("[ERR] %0t no bus answer", $time);
            end_of_test();
        end
    endtask : wb
    // Masked register read and compare
    task automatic rchk(input logic [4:0] a, input logic [31:0] msk, input logic [31:0] e, input string what);
        wb(1'b0, a, 8'h00);
        chk(rd & msk, e, what);
    endtask : rchk
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(5'h08, 32'hFFFFFFFF, 32'h00000000, "ctrl reset");
        rchk(5'h04, 32'hFFFFFFFF, 32'h00000000, "status reset");
        rchk(5'h10, 32'hFFFFFFFF, 32'h000000FF, "dir reset");
        rchk(5'h18, 32'hFFFFFFFF, 32'h00000000, "unmapped");
        wb(1'b1, 5'h0C, 8'hA4);
        wb(1'b1, 5'h08, 8'h26);
        wb(1'b1, 5'h14, 8'h02);
        m.start();
        repeat (10) @(posedge clk_i);
        rchk(5'h04, 32'h00000018, 32'h00000008, "start bit");
        chk({31'h00000000, irq_o}, 32'h00000001, "irq on start");
        wb(1'b1, 5'h14, 8'h03);
        m.wr_byte(8'hA5, ackb);
        chk({31'h00000000, ackb}, 32'h00000000, "address ack");
        repeat (10) @(posedge clk_i);
        chk({31'h00000000, scl_oe_o}, 32'h00000001, "clock held");
        rchk(5'h04, 32'h00000004, 32'h00000004, "rw bit");
        rchk(5'h00, 32'h000000FF, 32'h000000A5, "address in buffer");
        wb(1'b1, 5'h14, 8'h03);
        wb(1'b1, 5'h00, 8'h96);
        repeat (40) @(posedge clk_i);
        chk({31'h00000000, scl_oe_o}, 32'h00000001, "held until release");
        wb(1'b1, 5'h08, 8'h36);
        repeat (2) @(posedge clk_i);
        chk({31'h00000000, scl_oe_o}, 32'h00000000, "clock released");
        m.rd_byte(1'b0, rx);
        chk({24'h000000, rx}, 32'h00000096, "first byte");
        repeat (10) @(posedge clk_i);
        chk({31'h00000000, irq_o}, 32'h00000001, "irq per byte");
        wb(1'b1, 5'h14, 8'h03);
        wb(1'b1, 5'h00, 8'h3C);
        wb(1'b1, 5'h08, 8'h36);
        m.rd_byte(1'b1, rx);
        chk({24'h000000, rx}, 32'h0000003C, "last byte");
        repeat (10) @(posedge clk_i);
        rchk(5'h04, 32'h00000004, 32'h00000000, "nack resets status");
        wb(1'b1, 5'h14, 8'h03);
        m.stop();
        repeat (10) @(posedge clk_i);
        rchk(5'h04, 32'h00000018, 32'h00000010, "stop bit");
        chk({31'h00000000, irq_o}, 32'h00000001, "irq on stop");
        wb(1'b1, 5'h10, 8'hE7);
        repeat (2) @(posedge clk_i);
        chk({28'h0000000, sda_o, scl_o, sda_oe_o, scl_oe_o}, 32'h00000003, "pins driven");
        wb(1'b1, 5'h10, 8'hFF);
        repeat (2) @(posedge clk_i);
        chk({30'h00000000, sda_oe_o, scl_oe_o}, 32'h00000000, "pins released");
        wb(1'b1, 5'h08, 8'h06);
        rchk(5'h04, 32'h00000018, 32'h00000000, "cleared on disable");
        wb(1'b1, 5'h14, 8'h03);
        wb(1'b1, 5'h08, 8'h2B);
        m.start();
        repeat (10) @(posedge clk_i);
        rchk(5'h04, 32'h00000018, 32'h00000008, "start in idle mode");
        chk({31'h00000000, irq_o}, 32'h00000001, "irq in idle mode");
        m.stop();
        chk({31'h00000000, m_stuck}, 32'h00000000, "bus stall");
        end_of_test();
    end
endmodule : test_ssp_top
